// [srecc_pkg.sv]
// constants shared by the revision, debug-unlock enable and ecc error flag registers
//
// How it works
// - revision register returns a 16-bit packed bcd id in bits 15:0, upper bits zero
// - enable bit 0 set makes an interrupt while debug-lock status is set; resets off
// - flash bank 1 error sets bit 5 when ecc checking is enabled
// - flash bank 0 error sets bit 4 when ecc checking is enabled
// - instruction cache ecc error sets bit 3 when ecc checking is enabled
// - sram bank 3 error sets bit 2 when ecc checking is enabled
// - sram bank 2 error sets bit 1 when ecc checking is enabled
// - error in sram bank 0 or bank 1 sets shared bit 0 when enabled
// - reads of blank or erased flash count as ecc errors
`default_nettype none
package srecc_pkg;
    localparam int          ADDR_W          = 8;
    localparam int          DATA_W          = 32;
    localparam int          REV_W           = 16;
    localparam int          FLAG_W          = 6;
    localparam logic [7:0]  OFS_REVISION    = 8'h50;
    localparam logic [7:0]  OFS_SYSIE       = 8'h54;
    localparam logic [7:0]  OFS_ECCERR      = 8'h64;
    localparam int          BIT_UNLOCK_IE   = 0;
    localparam int          BIT_FLASH_BANK1_ERR      = 5;
    localparam int          BIT_FLASH_BANK0_ERR      = 4;
    localparam int          BIT_ICACHE      = 3;
    localparam int          BIT_SRAM3       = 2;
    localparam int          BIT_SRAM2       = 1;
    localparam int          BIT_SRAM01      = 0;
    localparam logic [5:0]  FLAGS_RESET     = 6'h00;
    localparam logic        UNLOCK_IE_RESET = 1'b0;
    localparam logic [31:0] READ_ZERO       = 32'h0000_0000;
endpackage : srecc_pkg
`default_nettype wire

// [srecc_regs.sv]
// register slice: chip revision, debug-unlock interrupt enable, sticky ecc error flags
`default_nettype none
module srecc_regs #(
    parameter logic [15:0] REVISION_ID = 16'h0042 // arbitrary neutral value
) (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        rst,
    // register port
    input  wire logic [7:0]  regAddr,
    input  wire logic [31:0] regWdata,
    input  wire logic        regWrite,
    input  wire logic        regRead,
    output var  logic [31:0] regRdata,
    // ecc checker events
    input  wire logic        eccEnable,
    input  wire logic        flashBank1Err,
    input  wire logic        flashBank0Err,
    input  wire logic        icacheErr,
    input  wire logic        sramBank3Err,
    input  wire logic        sramBank2Err,
    input  wire logic        sramBank0Err,
    input  wire logic        sramBank1Err,
    // debug lock status and interrupt
    input  wire logic        debugLockStatus,
    output var  logic        debugUnlockIrq,
    // flag view for neighbours
    output var  logic [5:0]  eccErrFlags
);
    logic       unlockIe_q;
    logic [5:0] flags_q;
    logic [5:0] flags_d;
    logic [5:0] setVec;
    logic [5:0] clrVec;
    logic       wrIe;
    logic       wrFlags;
    logic [31:0] rdMux;

    assign wrIe    = regWrite && (regAddr == srecc_pkg::OFS_SYSIE);
    assign wrFlags = regWrite && (regAddr == srecc_pkg::OFS_ECCERR);

    // error sources gated by the ecc enable; blank flash errors arrive on the same inputs
    always_comb
    begin
        setVec = srecc_pkg::FLAGS_RESET;
        setVec[srecc_pkg::BIT_FLASH_BANK1_ERR] = eccEnable && flashBank1Err;
        setVec[srecc_pkg::BIT_FLASH_BANK0_ERR] = eccEnable && flashBank0Err;
        setVec[srecc_pkg::BIT_ICACHE] = eccEnable && icacheErr;
        setVec[srecc_pkg::BIT_SRAM3]  = eccEnable && sramBank3Err;
        setVec[srecc_pkg::BIT_SRAM2]  = eccEnable && sramBank2Err;
        setVec[srecc_pkg::BIT_SRAM01] = eccEnable && (sramBank0Err || sramBank1Err);
    end

    // write one clears, writing zero keeps; set wins so no event is lost
    always_comb
    begin
        clrVec  = wrFlags ? regWdata[srecc_pkg::FLAG_W-1:0] : srecc_pkg::FLAGS_RESET;
        flags_d = (flags_q & ~clrVec) | setVec;
    end

    // sticky flags
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            flags_q <= srecc_pkg::FLAGS_RESET;
        else
            flags_q <= flags_d;
    end

    // debug-unlock interrupt enable
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            unlockIe_q <= srecc_pkg::UNLOCK_IE_RESET;
        else if (wrIe)
            unlockIe_q <= regWdata[srecc_pkg::BIT_UNLOCK_IE];
    end

    // interrupt registered so the output comes from a flop; one cycle behind the status
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            debugUnlockIrq <= 1'b0;
        else
            debugUnlockIrq <= unlockIe_q && debugLockStatus;
    end

    // read mux; unmapped addresses and reserved bits read zero
    always_comb
    begin
        rdMux = srecc_pkg::READ_ZERO;
        unique case (regAddr)
            srecc_pkg::OFS_REVISION: rdMux[srecc_pkg::REV_W-1:0]        = REVISION_ID;
            srecc_pkg::OFS_SYSIE:    rdMux[srecc_pkg::BIT_UNLOCK_IE]    = unlockIe_q;
            srecc_pkg::OFS_ECCERR:   rdMux[srecc_pkg::FLAG_W-1:0]       = flags_q;
            default:                 rdMux       = srecc_pkg::READ_ZERO;
        endcase
    end

    // read data stands only in the cycle after the strobe
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            regRdata <= srecc_pkg::READ_ZERO;
        else if (regRead)
            regRdata <= rdMux;
        else
            regRdata <= srecc_pkg::READ_ZERO;
    end

    // flag copy for outside use
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            eccErrFlags <= srecc_pkg::FLAGS_RESET;
        else
            eccErrFlags <= flags_d;
    end

    property p_set_wins;
        @(posedge clk) disable iff (rst)
        (eccEnable && flashBank1Err) |=> flags_q[srecc_pkg::BIT_FLASH_BANK1_ERR];
    endproperty
    a_set_wins: assert property (p_set_wins) else $error("flash_bank1_err event lost");

    property p_sram01;
        @(posedge clk) disable iff (rst)
        (eccEnable && (sramBank0Err || sramBank1Err)) |=> flags_q[srecc_pkg::BIT_SRAM01];
    endproperty
    a_sram01: assert property (p_sram01) else $error("sram01 flag not set");

    property p_no_set_disabled;
        @(posedge clk) disable iff (rst)
        (!eccEnable && !flags_q[srecc_pkg::BIT_ICACHE] && !wrFlags) |=> !flags_q[srecc_pkg::BIT_ICACHE];
    endproperty
    a_no_set_disabled: assert property (p_no_set_disabled) else $error("icache flag set while off");

    property p_w1c;
        @(posedge clk) disable iff (rst)
        (wrFlags && regWdata[srecc_pkg::BIT_SRAM3] && !(eccEnable && sramBank3Err))
            |=> !flags_q[srecc_pkg::BIT_SRAM3];
    endproperty
    a_w1c: assert property (p_w1c) else $error("sram3 not cleared");

    property p_sticky;
        @(posedge clk) disable iff (rst)
        (flags_q[srecc_pkg::BIT_SRAM2] && !(wrFlags && regWdata[srecc_pkg::BIT_SRAM2]))
            |=> flags_q[srecc_pkg::BIT_SRAM2];
    endproperty
    a_sticky: assert property (p_sticky) else $error("sram2 flag dropped");

    property p_flash_bank0_err;
        @(posedge clk) disable iff (rst)
        (eccEnable && flashBank0Err) ##1 (!regWrite) |=> flags_q[srecc_pkg::BIT_FLASH_BANK0_ERR];
    endproperty
    a_flash_bank0_err: assert property (p_flash_bank0_err) else $error("flash_bank0_err flag not held");

    property p_rev_read;
        @(posedge clk) disable iff (rst)
        (regRead && regAddr == srecc_pkg::OFS_REVISION)
            |=> (regRdata == {{(srecc_pkg::DATA_W - srecc_pkg::REV_W){1'b0}}, REVISION_ID});
    endproperty
    a_rev_read: assert property (p_rev_read) else $error("bad revision read");

    property p_irq;
        @(posedge clk) disable iff (rst)
        ##1 (debugUnlockIrq == $past(unlockIe_q && debugLockStatus));
    endproperty
    a_irq: assert property (p_irq) else $error("irq mismatch");

    property p_reserved;
        @(posedge clk) disable iff (rst)
        regRead
            |=> (regRdata[srecc_pkg::DATA_W-1:srecc_pkg::REV_W]
                 == srecc_pkg::READ_ZERO[srecc_pkg::DATA_W-1:srecc_pkg::REV_W]);
    endproperty
    a_reserved: assert property (p_reserved) else $error("reserved bits nonzero");

    // per-source set checks: each checker event, gated by the enable, must land in its own bit;
    // the sequence checks above cover the set/clear race, these cover the plain mapping so a
    // swapped bit position between two sources cannot slip through unnoticed

    // flash bank 0 event sets bit 4, blank reads included
    property p_flash_bank0_err_set;
        @(posedge clk) disable iff (rst)
        (eccEnable && flashBank0Err)
            |=> flags_q[srecc_pkg::BIT_FLASH_BANK0_ERR];
    endproperty
    a_flash_bank0_err_set: assert property (p_flash_bank0_err_set) else $error("flash_bank0_err flag not set");

    // cache event sets bit 3
    property p_icache_set;
        @(posedge clk) disable iff (rst)
        (eccEnable && icacheErr)
            |=> flags_q[srecc_pkg::BIT_ICACHE];
    endproperty
    a_icache_set: assert property (p_icache_set) else $error("icache flag not set");

    // sram bank 3 event sets bit 2
    property p_sram3_set;
        @(posedge clk) disable iff (rst)
        (eccEnable && sramBank3Err)
            |=> flags_q[srecc_pkg::BIT_SRAM3];
    endproperty
    a_sram3_set: assert property (p_sram3_set) else $error("sram3 flag not set");

    // sram bank 2 event sets bit 1
    property p_sram2_set;
        @(posedge clk) disable iff (rst)
        (eccEnable && sramBank2Err)
            |=> flags_q[srecc_pkg::BIT_SRAM2];
    endproperty
    a_sram2_set: assert property (p_sram2_set) else $error("sram2 flag not set");

    // flash bank 1 events are ignored while checking is off
    property p_flash_bank1_err_off;
        @(posedge clk) disable iff (rst)
        (!eccEnable && !flags_q[srecc_pkg::BIT_FLASH_BANK1_ERR])
            |=> !flags_q[srecc_pkg::BIT_FLASH_BANK1_ERR];
    endproperty
    a_flash_bank1_err_off: assert property (p_flash_bank1_err_off) else $error("flash_bank1_err flag set while off");

    // flash bank 0 events are ignored while checking is off
    property p_flash_bank0_err_off;
        @(posedge clk) disable iff (rst)
        (!eccEnable && !flags_q[srecc_pkg::BIT_FLASH_BANK0_ERR])
            |=> !flags_q[srecc_pkg::BIT_FLASH_BANK0_ERR];
    endproperty
    a_flash_bank0_err_off: assert property (p_flash_bank0_err_off) else $error("flash_bank0_err flag set while off");

    // shared sram flag only rises on an event from one of its two banks
    property p_sram01_quiet;
        @(posedge clk) disable iff (rst)
        (!flags_q[srecc_pkg::BIT_SRAM01] && !(eccEnable && (sramBank0Err || sramBank1Err)))
            |=> !flags_q[srecc_pkg::BIT_SRAM01];
    endproperty
    a_sram01_quiet: assert property (p_sram01_quiet) else $error("sram01 flag rose alone");

    // enable bit takes the written value
    property p_ie_write;
        @(posedge clk) disable iff (rst)
        wrIe
            |=> (unlockIe_q == $past(regWdata[srecc_pkg::BIT_UNLOCK_IE]));
    endproperty
    a_ie_write: assert property (p_ie_write) else $error("unlock enable not written");

    // enable reads back in bit 0, the rest zero
    property p_ie_read;
        @(posedge clk) disable iff (rst)
        (regRead && regAddr == srecc_pkg::OFS_SYSIE)
            |=> (regRdata == {{(srecc_pkg::DATA_W - 1){1'b0}}, $past(unlockIe_q)});
    endproperty
    a_ie_read: assert property (p_ie_read) else $error("bad unlock enable read");

    // flag register reads back the flags as they stood at the strobe
    property p_flags_read;
        @(posedge clk) disable iff (rst)
        (regRead && regAddr == srecc_pkg::OFS_ECCERR)
            |=> (regRdata == {{(srecc_pkg::DATA_W - srecc_pkg::FLAG_W){1'b0}}, $past(flags_q)});
    endproperty
    a_flags_read: assert property (p_flags_read) else $error("bad flag read");

    // read data only stand for one cycle; a stale word would hide a missed read
    property p_rd_idle;
        @(posedge clk) disable iff (rst)
        !regRead
            |=> (regRdata == srecc_pkg::READ_ZERO);
    endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data not zero when idle");

    // exported copy tracks the flag register
    property p_copy;
        @(posedge clk) disable iff (rst)
        1'b1
            |=> (eccErrFlags == flags_q);
    endproperty
    a_copy: assert property (p_copy) else $error("flag copy differs");

    // interrupt stays quiet while the enable is off
    property p_irq_off;
        @(posedge clk) disable iff (rst)
        !unlockIe_q
            |=> !debugUnlockIrq;
    endproperty
    a_irq_off: assert property (p_irq_off) else $error("irq while disabled");

    // interrupt follows an enabled, set status one cycle later
    property p_irq_on;
        @(posedge clk) disable iff (rst)
        (unlockIe_q && debugLockStatus)
            |=> debugUnlockIrq;
    endproperty
    a_irq_on: assert property (p_irq_on) else $error("irq missing");

    // writing zeros to the flag register keeps every flag
    property p_w0_keeps;
        @(posedge clk) disable iff (rst)
        (wrFlags && regWdata[srecc_pkg::FLAG_W-1:0] == srecc_pkg::FLAGS_RESET)
            |=> ((flags_q & $past(flags_q)) == $past(flags_q));
    endproperty
    a_w0_keeps: assert property (p_w0_keeps) else $error("flag lost on zero write");

    // revision register ignores writes
    property p_rev_const;
        @(posedge clk) disable iff (rst)
        (regRead && regAddr == srecc_pkg::OFS_REVISION && $past(regWrite))
            |=> (regRdata[srecc_pkg::REV_W-1:0] == REVISION_ID);
    endproperty
    a_rev_const: assert property (p_rev_const) else $error("revision changed by write");

    c_flag_set: cover property (@(posedge clk) disable iff (rst) $rose(flags_q[srecc_pkg::BIT_FLASH_BANK1_ERR]));
    c_clear: cover property (@(posedge clk) disable iff (rst) $fell(flags_q[srecc_pkg::BIT_SRAM3]));
    c_collide: cover property (@(posedge clk) disable iff (rst)
        wrFlags && regWdata[srecc_pkg::BIT_SRAM01] && setVec[srecc_pkg::BIT_SRAM01]);
    c_irq: cover property (@(posedge clk) disable iff (rst) $rose(debugUnlockIrq));
endmodule : srecc_regs
`default_nettype wire

// [srecc_regs_tb.sv]
// self-checking bench for the revision, unlock enable and ecc flag register slice
`default_nettype none
module srecc_regs_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [15:0] REV = 16'h0137; // arbitrary neutral value
    logic        clk, rst, regWrite, regRead, eccEnable, debugLockStatus;
    logic [7:0]  regAddr;
    logic [31:0] regWdata, regRdata, rdExp;
    logic [6:0]  ev;
    logic [5:0]  eccErrFlags, fExp;
    logic        debugUnlockIrq, ieExp, irqExp;
    logic [7:0]  amap [4] = '{8'h50, 8'h54, 8'h64, 8'h58};
    int          nErrors, samplesChecked, i;
    logic [31:0] r;
    srecc_regs #(.REVISION_ID(REV)) srecc_regs_inst (.clk(clk), .rst(rst), .regAddr(regAddr),
        .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata),
        .eccEnable(eccEnable), .flashBank1Err(ev[0]), .flashBank0Err(ev[1]), .icacheErr(ev[2]),
        .sramBank3Err(ev[3]), .sramBank2Err(ev[4]), .sramBank0Err(ev[5]), .sramBank1Err(ev[6]),
        .debugLockStatus(debugLockStatus), .debugUnlockIrq(debugUnlockIrq), .eccErrFlags(eccErrFlags));
    initial
    begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    // reference model; read data reflect state before the edge, set beats clear
    always @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            fExp = 6'h00; ieExp = 1'b0; irqExp = 1'b0; rdExp = 32'h0000_0000;
        end
        else
        begin
            rdExp = 32'h0000_0000;
            if (regRead && regAddr == 8'h50) rdExp = {16'h0000, REV};
            if (regRead && regAddr == 8'h54) rdExp = {31'h0, ieExp};
            if (regRead && regAddr == 8'h64) rdExp = {26'h0, fExp};
            irqExp = ieExp & debugLockStatus;
            if (regWrite && regAddr == 8'h54) ieExp = regWdata[0];
            if (regWrite && regAddr == 8'h64) fExp = fExp & ~regWdata[5:0];
            if (eccEnable) fExp = fExp | {ev[0], ev[1], ev[2], ev[3], ev[4], ev[5] | ev[6]};
        end
    end
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        samplesChecked++;
        if (g !== e)
        begin
            nErrors++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    // every settled cycle out of reset is compared against the model
    always @(negedge clk)
    begin
        if (!rst)
        begin
            chk("regRdata", rdExp, regRdata);
            chk("eccErrFlags", {26'h0, fExp}, {26'h0, eccErrFlags});
            chk("debugUnlockIrq", {31'h0, irqExp}, {31'h0, debugUnlockIrq});
        end
    end
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        regWrite <= w; regRead <= ~w; regAddr <= a; regWdata <= d;
        @(posedge clk);
        regWrite <= 1'b0; regRead <= 1'b0;
    endtask : bus
    task automatic doReset();
        rst <= 1'b1;
        repeat (20) @(posedge clk);
        rst <= 1'b0;
    endtask : doReset
    task automatic completeRun();
        $display("checks %0d mismatches %0d", samplesChecked, nErrors);
        if (nErrors == 0 && samplesChecked > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : completeRun
    initial
    begin
        rst = 1'b1; regWrite = 1'b0; regRead = 1'b0; regAddr = 8'h00; regWdata = 32'h0;
        eccEnable = 1'b0; debugLockStatus = 1'b0; ev = 7'h00; nErrors = 0; samplesChecked = 0;
        void'($urandom(51973));
        doReset();
        // reset values, unmapped place, read-only revision
        for (i = 0; i < 4; i++) bus(1'b0, amap[i], 32'h0);
        bus(1'b1, 8'h50, 32'hFFFF_FFFF); bus(1'b0, 8'h50, 32'h0);
        bus(1'b1, 8'h58, 32'hFFFF_FFFF); bus(1'b0, 8'h58, 32'h0);
        $display("test reset and read-only done");
        // unlock interrupt enable with status toggling
        debugLockStatus <= 1'b1; bus(1'b1, 8'h54, 32'hFFFF_FFFF); bus(1'b0, 8'h54, 32'h0);
        debugLockStatus <= 1'b0; bus(1'b1, 8'h54, 32'h0); debugLockStatus <= 1'b1; bus(1'b0, 8'h54, 32'h0);
        $display("test unlock enable done");
        // each source, disabled then enabled, write zero then write one
        for (i = 0; i < 7; i++)
        begin
            @(posedge clk); ev <= 7'(1 << i); eccEnable <= 1'b0;
            @(posedge clk); ev <= 7'h00; bus(1'b0, 8'h64, 32'h0);
            @(posedge clk); ev <= 7'(1 << i); eccEnable <= 1'b1;
            @(posedge clk); ev <= 7'h00; bus(1'b0, 8'h64, 32'h0);
            bus(1'b1, 8'h64, 32'hFFFF_FFC0); bus(1'b1, 8'h64, 32'h0000_003F);
        end
        // new error at the same edge as the clearing write
        @(posedge clk); ev <= 7'h7F; regWrite <= 1'b1; regAddr <= 8'h64; regWdata <= 32'h3F;
        @(posedge clk); ev <= 7'h00; regWrite <= 1'b0; bus(1'b0, 8'h64, 32'h0);
        $display("test sources and clearing done");
        // random traffic, back-to-back strobes, then a reset in mid-run
        for (i = 0; i < 400; i++)
        begin
            @(posedge clk);
            r = $urandom;
            regWrite <= r[0]; regRead <= ~r[0] & r[1]; regAddr <= amap[r[3:2]];
            regWdata <= $urandom; ev <= r[10:4] & r[17:11]; eccEnable <= r[18]; debugLockStatus <= r[19];
            if (i == 200) doReset();
        end
        @(posedge clk); regWrite <= 1'b0; regRead <= 1'b0; ev <= 7'h00;
        repeat (3) @(posedge clk);
        $display("test random done");
        completeRun();
    end
endmodule : srecc_regs_tb_top
`default_nettype wire
